/* common/acf_pkg.sv */
// shared constants for the converter configuration and result formatting block
package acf_pkg;
    // register offsets on the plain register port
    localparam logic [2:0] ACF_OFF_CONTROL = 3'h0;
    localparam logic [2:0] ACF_OFF_CONFIG = 3'h1;
    localparam logic [2:0] ACF_OFF_RES_HI = 3'h2;
    localparam logic [2:0] ACF_OFF_RES_LO = 3'h3;
    localparam logic [2:0] ACF_OFF_IRQ_STAT = 3'h4;
    localparam logic [2:0] ACF_OFF_IRQ_MASK = 3'h5;
    // configuration field positions
    localparam int ACF_CFG_JUST_BIT = 7;
    localparam int ACF_CFG_CS_LSB = 4;
    localparam int ACF_CFG_REF_LSB = 0;
    localparam logic [7:0] ACF_CFG_WMASK = 8'hf3;
    localparam logic [7:0] ACF_CFG_RESET = 8'h00;
    // control field positions
    localparam int ACF_CTL_ON_BIT = 0;
    localparam int ACF_CTL_GO_BIT = 1;
    localparam int ACF_CTL_CH_LSB = 2;
    localparam logic [7:0] ACF_CTL_WMASK = 8'h7f;
    localparam logic [7:0] ACF_CTL_RESET = 8'h00;
    // interrupt status bit
    localparam int ACF_IRQ_DONE_BIT = 0;
    localparam logic [7:0] ACF_IRQ_RESET = 8'h00;
    // positive reference codes
    localparam logic [1:0] ACF_REF_SUPPLY = 2'h0;
    localparam logic [1:0] ACF_REF_EXT_PIN = 2'h2;
    localparam logic [1:0] ACF_REF_FIXED = 2'h3;
    // number of result bits
    localparam int ACF_RES_BITS = 10;
    localparam logic [3:0] ACF_LAST_BIT = 4'h9;
    // conversion clock selection
    typedef enum {ACF_SRC_DIV, ACF_SRC_RC} acf_src_t;

    // half period (in system clocks) of the divided conversion clock, 0 = rc
    function automatic logic [5:0] acf_half_div(input logic [2:0] code);
        case (code)
            3'h0: acf_half_div = 6'h01;
            3'h1: acf_half_div = 6'h04;
            3'h2: acf_half_div = 6'h10;
            3'h4: acf_half_div = 6'h02;
            3'h5: acf_half_div = 6'h08;
            3'h6: acf_half_div = 6'h20;
            default: acf_half_div = 6'h00;
        endcase
    endfunction
endpackage

/* rtl/acf_clk_div.sv */
// conversion clock divider with rc oscillator bypass
`timescale 1ns/1ps
module acf_clk_div
    import acf_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // selection
    input wire logic [2:0] i_sel,
    input wire logic i_rc_tick,
    // conversion clock tick
    output logic o_tick,
    output logic o_use_rc
);
    logic [5:0] cnt_reg;
    logic [5:0] half;

    assign half = acf_half_div(i_sel);

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            cnt_reg <= 6'h00;
            o_tick <= 1'b0;
            o_use_rc <= 1'b0;
        end
        else
        begin
            o_use_rc <= (half == 6'h00);
            if (half == 6'h00)
            begin
                cnt_reg <= 6'h00;
                o_tick <= i_rc_tick;
            end
            else if ({1'b0, cnt_reg} + 7'h01 >= {half, 1'b0})
            begin
                cnt_reg <= 6'h00;
                o_tick <= 1'b1;
            end
            else
            begin
                cnt_reg <= cnt_reg + 6'h01;
                o_tick <= 1'b0;
            end
        end
    end
endmodule

/* rtl/acf_result_reg.sv */
// two-byte result storage with formatting on load
`timescale 1ns/1ps
module acf_result_reg
    import acf_pkg::*;
(
    // clock
    input wire logic i_ref_clk,
    // hardware load
    input wire logic i_load,
    input wire logic [9:0] i_value,
    input wire logic i_right,
    // software writes
    input wire logic i_wr_hi,
    input wire logic i_wr_lo,
    input wire logic [7:0] i_wdata,
    // stored bytes
    output logic [7:0] o_hi,
    output logic [7:0] o_lo
);
    // no reset: contents survive every reset
    always_ff @(posedge i_ref_clk)
    begin
        if (i_load)
        begin
            if (i_right)
            begin
                o_hi <= {6'h00, i_value[9:8]};
                o_lo <= i_value[7:0];
            end
            else
            begin
                o_hi <= i_value[9:2];
                o_lo <= {i_value[1:0], 6'h00};
            end
        end
        else
        begin
            if (i_wr_hi)
            begin
                o_hi <= i_wdata;
            end
            if (i_wr_lo)
            begin
                o_lo <= i_wdata;
            end
        end
    end
endmodule

/* rtl/acf_top.sv */
// converter configuration, sequencing and result formatting
// Function
// - right justify zeroes high byte upper six
// - left justify zeroes low byte lower six
// - clock select divides system clock
// - codes 011 and 111 pick rc oscillator
// - reference field selects supply, pin, fixed
// - config bits 3 and 2 read zero
// - left mode places result bits high first
// - right mode places high two bits low
// - result bytes software writable, reset keeps
// - config fields clear on every reset
// - done clears busy, flags, loads result
// - early abort loads partial, fills last bit
`timescale 1ns/1ps
module acf_top
    import acf_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // register port
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // analog core
    input wire logic i_rc_tick,
    input wire logic i_cmp,
    output logic o_conv_clk,
    output logic o_use_rc,
    output logic [1:0] o_pos_ref,
    output logic [4:0] o_channel,
    output logic o_sample,
    output logic [9:0] o_trial,
    // interrupt
    output logic o_irq
);
    typedef enum {ACF_IDLE, ACF_SAMPLE, ACF_CONV} acf_state_t;

    logic [7:0] config_reg;
    logic [7:0] control_reg;
    logic [7:0] irq_stat_reg;
    logic [7:0] irq_mask_reg;
    logic [9:0] sar_reg;
    logic [3:0] bit_reg;
    logic last_bit_reg;
    logic any_done_reg;
    acf_state_t state_reg;
    logic tick;
    logic use_rc;
    logic [7:0] res_hi;
    logic [7:0] res_lo;
    logic load;
    logic [9:0] load_value;
    logic done;
    logic abort;
    logic wr_ctl;
    logic go_bit;

    assign wr_ctl = i_wr && (i_addr == ACF_OFF_CONTROL);
    assign go_bit = control_reg[ACF_CTL_GO_BIT];

    acf_clk_div u_div (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_sel(config_reg[ACF_CFG_CS_LSB +: 3]),
        .i_rc_tick(i_rc_tick),
        .o_tick(tick),
        .o_use_rc(use_rc)
    );

    // fill unconverted bits with the last decided bit
    function automatic logic [9:0] acf_partial(input logic [9:0] v, input logic [3:0] pos,
        input logic fill);
        logic [9:0] r;
        r = v;
        for (int k = 0; k < ACF_RES_BITS; k++)
        begin
            if (k[3:0] <= pos)
            begin
                r[k] = fill;
            end
        end
        acf_partial = r;
    endfunction

    assign done = (state_reg == ACF_CONV) && tick && (bit_reg == 4'h0) && go_bit;
    assign abort = (state_reg == ACF_CONV) && !go_bit;
    assign load = done || abort;
    assign load_value = done ? (sar_reg | (i_cmp ? 10'h001 : 10'h000)) & ~10'h000
        : acf_partial(sar_reg, bit_reg, last_bit_reg);

    acf_result_reg u_res (
        .i_ref_clk(i_ref_clk),
        .i_load(load),
        .i_value(load_value),
        .i_right(config_reg[ACF_CFG_JUST_BIT]),
        .i_wr_hi(i_wr && (i_addr == ACF_OFF_RES_HI)),
        .i_wr_lo(i_wr && (i_addr == ACF_OFF_RES_LO)),
        .i_wdata(i_wdata),
        .o_hi(res_hi),
        .o_lo(res_lo)
    );

    // configuration register
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            config_reg <= ACF_CFG_RESET;
        end
        else if (i_wr && (i_addr == ACF_OFF_CONFIG))
        begin
            config_reg <= i_wdata & ACF_CFG_WMASK;
        end
    end

    // control register; hardware clears go on completion
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            control_reg <= ACF_CTL_RESET;
        end
        else if (wr_ctl)
        begin
            control_reg <= i_wdata & ACF_CTL_WMASK;
        end
        else if (done || !control_reg[ACF_CTL_ON_BIT])
        begin
            control_reg[ACF_CTL_GO_BIT] <= 1'b0;
        end
    end

    // successive approximation sequencer
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            state_reg <= ACF_IDLE;
            sar_reg <= 10'h000;
            bit_reg <= ACF_LAST_BIT;
            last_bit_reg <= 1'b0;
        end
        else
        begin
            case (state_reg)
                ACF_IDLE:
                begin
                    if (go_bit && control_reg[ACF_CTL_ON_BIT] && !wr_ctl)
                    begin
                        state_reg <= ACF_SAMPLE;
                    end
                end
                ACF_SAMPLE:
                begin
                    if (!go_bit)
                    begin
                        state_reg <= ACF_IDLE;
                    end
                    else if (tick)
                    begin
                        state_reg <= ACF_CONV;
                        sar_reg <= 10'h000;
                        bit_reg <= ACF_LAST_BIT;
                        last_bit_reg <= 1'b0;
                    end
                end
                ACF_CONV:
                begin
                    if (load)
                    begin
                        state_reg <= ACF_IDLE;
                    end
                    else if (tick)
                    begin
                        sar_reg[bit_reg] <= i_cmp;
                        last_bit_reg <= i_cmp;
                        bit_reg <= bit_reg - 4'h1;
                    end
                end
                default:
                begin
                    state_reg <= ACF_IDLE;
                end
            endcase
        end
    end

    // interrupt status, mask and output
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            irq_stat_reg <= ACF_IRQ_RESET;
            irq_mask_reg <= ACF_IRQ_RESET;
            o_irq <= 1'b0;
        end
        else
        begin
            if (i_wr && (i_addr == ACF_OFF_IRQ_MASK))
            begin
                irq_mask_reg <= i_wdata;
            end
            if (done)
            begin
                irq_stat_reg[ACF_IRQ_DONE_BIT] <= 1'b1;
            end
            else if (i_rd && (i_addr == ACF_OFF_IRQ_STAT))
            begin
                irq_stat_reg <= ACF_IRQ_RESET;
            end
            o_irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // read port and analog side outputs
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            o_rdata <= 8'h00;
            o_conv_clk <= 1'b0;
            o_use_rc <= 1'b0;
            o_pos_ref <= ACF_REF_SUPPLY;
            o_channel <= 5'h00;
            o_sample <= 1'b0;
            o_trial <= 10'h000;
            any_done_reg <= 1'b0;
        end
        else
        begin
            o_rdata <= 8'h00;
            if (i_rd)
            begin
                case (i_addr)
                    ACF_OFF_CONTROL: o_rdata <= control_reg;
                    ACF_OFF_CONFIG: o_rdata <= config_reg;
                    ACF_OFF_RES_HI: o_rdata <= res_hi;
                    ACF_OFF_RES_LO: o_rdata <= res_lo;
                    ACF_OFF_IRQ_STAT: o_rdata <= irq_stat_reg;
                    ACF_OFF_IRQ_MASK: o_rdata <= irq_mask_reg;
                    default: o_rdata <= 8'h00;
                endcase
            end
            o_conv_clk <= tick;
            o_use_rc <= use_rc;
            o_pos_ref <= config_reg[ACF_CFG_REF_LSB +: 2];
            o_channel <= control_reg[ACF_CTL_CH_LSB +: 5];
            o_sample <= (state_reg == ACF_SAMPLE) || (state_reg == ACF_IDLE);
            o_trial <= sar_reg | (state_reg == ACF_CONV ? (10'h001 << bit_reg) : 10'h000);
            any_done_reg <= any_done_reg || load;
        end
    end

    // checks
    property p_right_hi;
        @(posedge i_ref_clk) disable iff (i_rst)
        load && config_reg[ACF_CFG_JUST_BIT] |=> res_hi[7:2] == 6'h00;
    endproperty
    a_right_hi: assert property (p_right_hi) else $error("right hi not zeroed");

    property p_left_lo;
        @(posedge i_ref_clk) disable iff (i_rst)
        load && !config_reg[ACF_CFG_JUST_BIT] |=> res_lo[5:0] == 6'h00;
    endproperty
    a_left_lo: assert property (p_left_lo) else $error("left lo not zeroed");

    property p_left_place;
        @(posedge i_ref_clk) disable iff (i_rst)
        load && !config_reg[ACF_CFG_JUST_BIT] |=>
            {res_hi, res_lo[7:6]} == $past(load_value);
    endproperty
    a_left_place: assert property (p_left_place) else $error("left placement wrong");

    property p_right_place;
        @(posedge i_ref_clk) disable iff (i_rst)
        load && config_reg[ACF_CFG_JUST_BIT] |=>
            {res_hi[1:0], res_lo} == $past(load_value);
    endproperty
    a_right_place: assert property (p_right_place) else $error("right placement wrong");

    property p_cfg_zero;
        @(posedge i_ref_clk) disable iff (i_rst) config_reg[3:2] == 2'h0;
    endproperty
    a_cfg_zero: assert property (p_cfg_zero) else $error("config bits 3:2 set");

    property p_cfg_reset;
        @(posedge i_ref_clk) i_rst |=> config_reg == ACF_CFG_RESET;
    endproperty
    a_cfg_reset: assert property (p_cfg_reset) else $error("config not cleared");

    sequence s_done;
        done;
    endsequence
    property p_done;
        @(posedge i_ref_clk) disable iff (i_rst)
        s_done ##0 !wr_ctl |=> !go_bit && irq_stat_reg[ACF_IRQ_DONE_BIT] && state_reg == ACF_IDLE;
    endproperty
    a_done: assert property (p_done) else $error("completion incomplete");

    property p_abort;
        @(posedge i_ref_clk) disable iff (i_rst)
        abort |-> ((load_value ^ {10{last_bit_reg}}) & ~(10'h3fe << bit_reg)) == 10'h000
            ##1 state_reg == ACF_IDLE && any_done_reg;
    endproperty
    a_abort: assert property (p_abort) else $error("abort not handled");

    property p_rc;
        @(posedge i_ref_clk) disable iff (i_rst)
        config_reg[5:4] == 2'h3 ##1 config_reg[5:4] == 2'h3 |=> use_rc;
    endproperty
    a_rc: assert property (p_rc) else $error("rc not selected");

    property p_ref;
        @(posedge i_ref_clk) disable iff (i_rst)
        1'b1 |=> o_pos_ref == $past(config_reg[1:0]);
    endproperty
    a_ref: assert property (p_ref) else $error("reference mismatch");
endmodule

/* dv/acf_core_model.sv */
// analog core stand-in: comparator against a held input level and an rc tick source
`timescale 1ns/1ps
module acf_core_model
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // converter side
    input wire logic [9:0] i_trial,
    input wire logic [9:0] i_level,
    output logic o_cmp,
    output logic o_rc_tick
);
    logic [1:0] rc_cnt_reg;
    // rc oscillator runs free, one pulse every third cycle
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
            rc_cnt_reg <= 2'h0;
        else
            rc_cnt_reg <= (rc_cnt_reg == 2'h2) ? 2'h0 : rc_cnt_reg + 2'h1;
    end
    assign o_rc_tick = (rc_cnt_reg == 2'h2);
    // trial bit kept while the input is at or above the trial word
    assign o_cmp = (i_level >= i_trial);
endmodule

/* dv/acf_top_tb.sv */
// self-checking bench for the converter configuration and result block
`timescale 1ns/1ps
module acf_top_tb;
    import acf_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [2:0] i_addr = 3'h0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] o_rdata;
    logic i_rc_tick, i_cmp, o_conv_clk, o_use_rc, o_sample, o_irq;
    logic [1:0] o_pos_ref;
    logic [4:0] o_channel;
    logic [9:0] o_trial;
    logic [9:0] level = 10'h000;
    logic [7:0] v;
    int n_fail = 0;
    int num_checks = 0;
    integer seed = 32'h9276da45;
    int ratio [8] = '{2, 8, 32, 3, 4, 16, 64, 3};

    acf_top i_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_rc_tick(i_rc_tick), .i_cmp(i_cmp), .o_conv_clk(o_conv_clk),
        .o_use_rc(o_use_rc), .o_pos_ref(o_pos_ref), .o_channel(o_channel),
        .o_sample(o_sample), .o_trial(o_trial), .o_irq(o_irq));
    acf_core_model i_core (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_trial(o_trial),
        .i_level(level), .o_cmp(i_cmp), .o_rc_tick(i_rc_tick));

    always #5 i_ref_clk = ~i_ref_clk;

    task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // one conversion; stop below 11 aborts after that many clock pulses
    task automatic convert(input logic [2:0] cs, input logic just, input int stop);
        int gap, last, k;
        logic [9:0] res;
        logic [7:0] hi, lo;
        level = $random(seed);
        res = level;
        wr(ACF_OFF_IRQ_MASK, {7'h0, just});
        wr(ACF_OFF_CONFIG, {just, cs, 4'h0});
        wr(ACF_OFF_CONTROL, {1'b0, level[4:0], 2'h1});
        repeat (20) @(posedge i_ref_clk);
        check("channel", o_channel, level[4:0]);
        check("use_rc", o_use_rc, cs[1:0] == 2'h3);
        // start an abort run just after a tick so every counted pulse is the sequencer's
        for (int t = 0; t < 200 && stop < 11 && o_conv_clk !== 1'b1; t++)
        begin
            @(posedge i_ref_clk);
            #1;
        end
        wr(ACF_OFF_CONTROL, {1'b0, level[4:0], 2'h3});
        k = 0;
        last = 0;
        gap = 0;
        for (int t = 0; t < 1000 && k < stop; t++)
        begin
            @(posedge i_ref_clk);
            #1;
            if (o_conv_clk === 1'b1)
            begin
                gap = t - last;
                last = t;
                k++;
            end
        end
        if (stop < 11)
        begin
            wr(ACF_OFF_CONTROL, 8'h01);
            for (int b = 0; b < 11 - stop; b++)
                res[b] = level[11 - stop];
        end
        else
            check("tick_gap", gap, ratio[cs]);
        v = 8'h02;
        for (int i = 0; i < 100 && v[1] !== 1'b0; i++)
            rd(ACF_OFF_CONTROL, v);
        check("go_clear", v[1], 1'b0);
        check("irq", o_irq, just && stop >= 11);
        rd(ACF_OFF_RES_HI, hi);
        rd(ACF_OFF_RES_LO, lo);
        if (just)
        begin
            check("hi_right", hi, {6'h0, res[9:8]});
            check("lo_right", lo, res[7:0]);
        end
        else
        begin
            check("hi_left", hi, res[9:2]);
            check("lo_left", lo, {res[1:0], 6'h0});
        end
        rd(ACF_OFF_IRQ_STAT, v);
        check("flag_set", v, {7'h0, stop >= 11});
        rd(ACF_OFF_IRQ_STAT, v);
        check("flag_clear", v, 8'h00);
        check("irq_off", o_irq, 1'b0);
    endtask

    initial
    begin
        #500000;
        n_fail++;
        results;
    end

    initial
    begin
        repeat (3) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        foreach (ratio[a])
        begin
            if (a != 2 && a != 3)
            begin
                rd(a[2:0], v);
                check("reset_val", v, 8'h00);
            end
        end
        wr(3'h6, 8'h5a);
        rd(3'h6, v);
        check("unmapped", v, 8'h00);
        check("sample_idle", o_sample, 1'b1);
        wr(ACF_OFF_CONFIG, 8'hff);
        rd(ACF_OFF_CONFIG, v);
        check("cfg_mask", v, 8'hf3);
        foreach (ratio[r])
        begin
            if (r != 1 && r < 4)
            begin
                wr(ACF_OFF_CONFIG, r[7:0]);
                rd(ACF_OFF_CONFIG, v);
                check("pos_ref", o_pos_ref, r[1:0]);
            end
        end
        wr(ACF_OFF_CONFIG, 8'hd2);
        wr(ACF_OFF_RES_HI, 8'h5a);
        wr(ACF_OFF_RES_LO, 8'ha5);
        @(posedge i_ref_clk);
        i_rst <= 1'b1;
        @(posedge i_ref_clk);
        i_rst <= 1'b0;
        rd(ACF_OFF_CONFIG, v);
        check("cfg_reset", v, 8'h00);
        rd(ACF_OFF_RES_HI, v);
        check("hi_keep", v, 8'h5a);
        rd(ACF_OFF_RES_LO, v);
        check("lo_keep", v, 8'ha5);
        for (int c = 0; c < 16; c++)
            convert(c[2:0], c[3], 11);
        convert(3'h6, 1'b0, 5);
        convert(3'h6, 1'b1, 3);
        results;
    end
endmodule
